/* inc/timer_core_defines.svh */
// register map, field positions and reset values of the timer core
`ifndef TIMER_CORE_DEFINES_SVH
`define TIMER_CORE_DEFINES_SVH
`define TC_AW 8
`define TC_OFF_COUNT 8'h00
`define TC_OFF_DIV 8'h04
`define TC_OFF_PERIOD 8'h08
`define TC_OFF_REPEAT 8'h0c
`define TC_OFF_CH1 8'h10
`define TC_OFF_CH2 8'h14
`define TC_OFF_CTRL 8'h18
`define TC_OFF_STATUS 8'h1c
`define TC_OFF_MASK 8'h20
`define TC_RST16 16'h0000
`define TC_RST8 8'h00
`define TC_RST_CTRL 11'h000
`define TC_RST_ST 3'h0
`define TC_CTRL_W 11
`define TC_REP_W 8
`define TC_ST_W 3
`define TC_ST_OVF 0
`define TC_ST_CH1 1
`define TC_ST_CH2 2
`define TC_ONE16 16'h0001
`define TC_ONE8 8'h01
`endif

/* inc/timer_core_pkg.sv */
// types shared by the timer core
`default_nettype none
package timer_core_pkg;
  typedef enum logic [2:0] {
    om_frozen = 3'b000,
    om_set_on_match = 3'b001,
    om_clr_on_match = 3'b010,
    om_toggle = 3'b011,
    om_force_low = 3'b100,
    om_force_high = 3'b101,
    om_pwm_a = 3'b110,
    om_pwm_b = 3'b111
  } out_mode_e;
  typedef struct packed {
    out_mode_e ch2_mode;
    out_mode_e ch1_mode;
    logic ch2_buf_en;
    logic ch1_buf_en;
    logic ch2_input;
    logic ch1_input;
    logic run;
  } ctrl_s;
  typedef struct packed {
    logic [15:0] compare;
    logic [15:0] count;
    logic match;
    logic evt;
  } cmp_in_s;
endpackage
`default_nettype wire

/* rtl/timer_core.sv */
// counting, repetition and channel 1/2 capture-compare core with apb
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "timer_core_defines.svh"
module timer_core (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // channel input events, one-cycle pulses
  input wire logic ch_one_input_event,
  input wire logic ch_two_input_event,
  // channel raw outputs and interrupt
  output logic ch_one_raw_output,
  output logic ch_two_raw_output,
  output logic irq
);
  logic [15:0] count_value_q;
  logic [15:0] div_q;
  logic [15:0] psc_act_q;
  logic [15:0] psc_cnt_q;
  logic [15:0] period_q;
  logic [`TC_REP_W-1:0] rep_set_q;
  logic [`TC_REP_W-1:0] rep_cnt_q;
  logic [15:0] c1_q;
  logic [15:0] c2_q;
  logic [15:0] act1_q;
  logic [15:0] act2_q;
  timer_core_pkg::ctrl_s ctrl_q;
  logic [`TC_ST_W-1:0] status_q;
  logic [`TC_ST_W-1:0] mask_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic out1_q;
  logic out2_q;
  logic match1_prev_q;
  logic match2_prev_q;

  // address decode, used by both read and write paths
  function automatic logic mapped(input logic [`TC_AW-1:0] a);
    case (a)
      `TC_OFF_COUNT, `TC_OFF_DIV, `TC_OFF_PERIOD, `TC_OFF_REPEAT,
      `TC_OFF_CH1, `TC_OFF_CH2, `TC_OFF_CTRL, `TC_OFF_STATUS,
      `TC_OFF_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // next raw output level for a channel in output mode
  function automatic logic out_next(
    input timer_core_pkg::out_mode_e mode,
    input logic cur,
    input timer_core_pkg::cmp_in_s c
  );
    case (mode)
      timer_core_pkg::om_frozen: out_next = cur;
      timer_core_pkg::om_set_on_match: out_next = c.evt ? 1'b1 : cur;
      timer_core_pkg::om_clr_on_match: out_next = c.evt ? 1'b0 : cur;
      timer_core_pkg::om_toggle: out_next = c.evt ? ~cur : cur;
      timer_core_pkg::om_force_low: out_next = 1'b0;
      timer_core_pkg::om_force_high: out_next = 1'b1;
      timer_core_pkg::om_pwm_a: out_next = c.count < c.compare;
      timer_core_pkg::om_pwm_b: out_next = c.count >= c.compare;
    endcase
  endfunction

  // apb: zero wait states, answer prepared in the setup cycle
  logic setup;
  logic wr_en;
  logic wr_ok;
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign wr_ok = wr_en & mapped(paddr);
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  function automatic logic wr_at(
    input logic ok,
    input logic [`TC_AW-1:0] a,
    input logic [`TC_AW-1:0] off
  );
    wr_at = ok & (a == off);
  endfunction

  logic wr_count;
  logic wr_div;
  logic wr_period;
  logic wr_repeat;
  logic wr_ch1;
  logic wr_ch2;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  assign wr_count = wr_at(wr_ok, paddr, `TC_OFF_COUNT);
  assign wr_div = wr_at(wr_ok, paddr, `TC_OFF_DIV);
  assign wr_period = wr_at(wr_ok, paddr, `TC_OFF_PERIOD);
  assign wr_repeat = wr_at(wr_ok, paddr, `TC_OFF_REPEAT);
  assign wr_ch1 = wr_at(wr_ok, paddr, `TC_OFF_CH1);
  assign wr_ch2 = wr_at(wr_ok, paddr, `TC_OFF_CH2);
  assign wr_ctrl = wr_at(wr_ok, paddr, `TC_OFF_CTRL);
  assign wr_status = wr_at(wr_ok, paddr, `TC_OFF_STATUS);
  assign wr_mask = wr_at(wr_ok, paddr, `TC_OFF_MASK);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `TC_OFF_COUNT: rd_mux[15:0] = count_value_q;
      `TC_OFF_DIV: rd_mux[15:0] = div_q;
      `TC_OFF_PERIOD: rd_mux[15:0] = period_q;
      `TC_OFF_REPEAT: rd_mux[`TC_REP_W-1:0] = rep_set_q;
      `TC_OFF_CH1: rd_mux[15:0] = c1_q;
      `TC_OFF_CH2: rd_mux[15:0] = c2_q;
      `TC_OFF_CTRL: rd_mux[`TC_CTRL_W-1:0] = ctrl_q;
      `TC_OFF_STATUS: rd_mux[`TC_ST_W-1:0] = status_q;
      `TC_OFF_MASK: rd_mux[`TC_ST_W-1:0] = mask_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_q <= ~mapped(paddr);
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= `TC_RST16;
      period_q <= `TC_RST16;
      rep_set_q <= `TC_RST8;
      ctrl_q <= `TC_RST_CTRL;
      mask_q <= `TC_RST_ST;
    end else begin
      if (wr_div) div_q <= pwdata[15:0];
      if (wr_period) period_q <= pwdata[15:0];
      if (wr_repeat) rep_set_q <= pwdata[`TC_REP_W-1:0];
      if (wr_ctrl) ctrl_q <= pwdata[`TC_CTRL_W-1:0];
      if (wr_mask) mask_q <= pwdata[`TC_ST_W-1:0];
    end
  end

  // prescaler and counter
  logic run_ok;
  logic tick;
  logic period_end;
  logic ovf;
  assign run_ok = ctrl_q.run & (period_q != `TC_RST16);
  assign tick = run_ok & (psc_cnt_q == psc_act_q);
  assign period_end = tick & (count_value_q >= period_q);
  assign ovf = period_end & (rep_cnt_q == `TC_RST8);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_cnt_q <= `TC_RST16;
    end else if (tick) begin
      psc_cnt_q <= `TC_RST16;
    end else if (run_ok) begin
      psc_cnt_q <= psc_cnt_q + `TC_ONE16;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_act_q <= `TC_RST16;
    end else if (ovf) begin
      psc_act_q <= div_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_q <= `TC_RST16;
    end else if (wr_count) begin
      count_value_q <= pwdata[15:0];
    end else if (period_end) begin
      count_value_q <= `TC_RST16;
    end else if (tick) begin
      count_value_q <= count_value_q + `TC_ONE16;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rep_cnt_q <= `TC_RST8;
    end else if (ovf) begin
      rep_cnt_q <= rep_set_q;
    end else if (period_end) begin
      rep_cnt_q <= rep_cnt_q - `TC_ONE8;
    end
  end

  // channel data: capture in input mode, compare value in output mode
  logic cap1;
  logic cap2;
  assign cap1 = ctrl_q.ch1_input & ch_one_input_event;
  assign cap2 = ctrl_q.ch2_input & ch_two_input_event;

  // a capture wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_q <= `TC_RST16;
    end else if (cap1) begin
      c1_q <= count_value_q;
    end else if (wr_ch1) begin
      c1_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c2_q <= `TC_RST16;
    end else if (cap2) begin
      c2_q <= count_value_q;
    end else if (wr_ch2) begin
      c2_q <= pwdata[15:0];
    end
  end

  // active compare copies follow the data register unless buffered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act1_q <= `TC_RST16;
      act2_q <= `TC_RST16;
    end else begin
      if (!ctrl_q.ch1_buf_en || ovf) act1_q <= c1_q;
      if (!ctrl_q.ch2_buf_en || ovf) act2_q <= c2_q;
    end
  end

  logic [15:0] cmp1;
  logic [15:0] cmp2;
  logic match1;
  logic match2;
  timer_core_pkg::cmp_in_s ci1;
  timer_core_pkg::cmp_in_s ci2;
  assign cmp1 = ctrl_q.ch1_buf_en ? act1_q : c1_q;
  assign cmp2 = ctrl_q.ch2_buf_en ? act2_q : c2_q;
  assign match1 = ~ctrl_q.ch1_input & (count_value_q == cmp1);
  assign match2 = ~ctrl_q.ch2_input & (count_value_q == cmp2);
  // a match acts once, on the cycle it begins
  assign ci1 = '{compare: cmp1, count: count_value_q, match: match1,
                 evt: match1 & ~match1_prev_q};
  assign ci2 = '{compare: cmp2, count: count_value_q, match: match2,
                 evt: match2 & ~match2_prev_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match1_prev_q <= 1'b1; // count and compare both leave reset at zero
      match2_prev_q <= 1'b1; // so no false match start after reset
    end else begin
      match1_prev_q <= match1;
      match2_prev_q <= match2;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out1_q <= 1'b0;
      out2_q <= 1'b0;
    end else begin
      if (!ctrl_q.ch1_input) begin
        out1_q <= out_next(ctrl_q.ch1_mode, out1_q, ci1);
      end
      if (!ctrl_q.ch2_input) begin
        out2_q <= out_next(ctrl_q.ch2_mode, out2_q, ci2);
      end
    end
  end
  assign ch_one_raw_output = out1_q;
  assign ch_two_raw_output = out2_q;

  // sticky status, write one to clear, a new event wins over the clear
  logic [`TC_ST_W-1:0] set_ev;
  always_comb begin
    set_ev = `TC_RST_ST;
    set_ev[`TC_ST_OVF] = ovf;
    set_ev[`TC_ST_CH1] = cap1 | ci1.evt;
    set_ev[`TC_ST_CH2] = cap2 | ci2.evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= `TC_RST_ST;
    end else begin
      status_q <= (status_q & ~(wr_status ? pwdata[`TC_ST_W-1:0] :
                  `TC_RST_ST)) | set_ev;
    end
  end
  assign irq = |(status_q & mask_q);

  // checks
  sequence s_rpr_setup;
    psel && !penable && !pwrite && paddr == `TC_OFF_REPEAT;
  endsequence
  sequence s_overflow;
    ovf && !wr_count;
  endsequence

  a_div_one: assert property (
    @(posedge pclk) disable iff (!presetn)
    run_ok && psc_act_q == `TC_RST16 |-> tick)
    else $error("undivided prescaler missed a tick");
  a_count_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && !period_end && !wr_count
    |=> count_value_q == $past(count_value_q) + `TC_ONE16)
    else $error("counter did not advance on tick");
  a_no_tick_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !tick && !wr_count |=> $stable(count_value_q))
    else $error("counter moved without a tick");
  a_div_buffered: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ovf |=> $stable(psc_act_q))
    else $error("working divider changed outside overflow");
  a_div_load: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_overflow |=> psc_act_q == $past(div_q))
    else $error("divider not loaded at overflow");
  a_period_wrap: assert property (
    @(posedge pclk) disable iff (!presetn)
    period_end && !wr_count |=> count_value_q == `TC_RST16)
    else $error("counter did not wrap at period");
  a_zero_stop: assert property (
    @(posedge pclk) disable iff (!presetn)
    period_q == `TC_RST16 |-> !tick && !ovf)
    else $error("timer ran with zero period");
  a_rep_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    period_end && rep_cnt_q != `TC_RST8 |-> !ovf
    ##1 rep_cnt_q == $past(rep_cnt_q) - `TC_ONE8)
    else $error("repetition counter did not gate overflow");
  a_rpr_upper: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_rpr_setup |=> prdata[15:8] == `TC_RST8)
    else $error("repetition upper byte read nonzero");
  a_cap_one: assert property (
    @(posedge pclk) disable iff (!presetn)
    cap1 |=> c1_q == $past(count_value_q))
    else $error("channel 1 capture lost");
  a_cap_two: assert property (
    @(posedge pclk) disable iff (!presetn)
    cap2 |=> c2_q == $past(count_value_q))
    else $error("channel 2 capture lost");
  a_cmp_toggle: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ctrl_q.ch1_input && ctrl_q.ch1_mode == timer_core_pkg::om_toggle
    && ci1.evt |=> ch_one_raw_output != $past(ch_one_raw_output))
    else $error("channel 1 toggle missed");
  a_pwm_two: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ctrl_q.ch2_input && ctrl_q.ch2_mode == timer_core_pkg::om_pwm_a
    |=> ch_two_raw_output == ($past(count_value_q) < $past(cmp2)))
    else $error("channel 2 pwm level wrong");
  a_cmp_direct: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ctrl_q.ch1_buf_en |-> cmp1 == c1_q)
    else $error("unbuffered compare not immediate");
  a_count_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_count |=> count_value_q == $past(pwdata[15:0]))
    else $error("counter write not applied");
endmodule
`default_nettype wire

/* tb/advanced_timer_count_capture_core_bench.sv */
// self-checking bench for the timer core
`timescale 1ns/1ps
`default_nettype none
`include "timer_core_defines.svh"
module advanced_timer_count_capture_core_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r, q;
  logic pready, pslverr, irq, e;
  logic ch_one_input_event, ch_two_input_event;
  logic ch_one_raw_output, ch_two_raw_output;
  logic fire_one = 1'b0;
  logic fire_two = 1'b0;
  int edges, ts, ta, tb, tc, td, te, e0;
  int cyc = 0;
  int bad_count = 0;
  int comparisons = 0;
  timer_core_pkg::ctrl_s c;
  timer_core_pkg::out_mode_e modes [6];
  logic [5:0] want = 6'b100110;

  timer_core timer_core_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ch_one_input_event,
    .ch_two_input_event, .ch_one_raw_output, .ch_two_raw_output, .irq);
  timer_core_pins timer_core_pins_i (.pclk, .fire_one, .fire_two,
    .ch_one_input_event, .ch_two_input_event, .ch_one_raw_output, .edges);

  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  task check(input string what, input logic [31:0] seen, input logic [31:0] x);
    comparisons++;
    if (seen !== x) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, x, seen);
    end
  endtask

  task results;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task timed_out;
    bad_count++;
    $display("wait limit reached");
    results();
  endtask

  task done(input string s);
    $display("test %s finished", s);
  endtask

  task do_reset;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // one apb transfer; held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timed_out();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input string what, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(what, q, x);
  endtask

  task setc;
    wr(`TC_OFF_CTRL, 32'(c));
  endtask

  task pulse(input logic one, input logic two);
    fire_one <= one;
    fire_two <= two;
    @(posedge pclk);
    fire_one <= 1'b0;
    fire_two <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task raw(input logic w1, input logic w2);
    check("raw one", {31'h0, ch_one_raw_output}, {31'h0, w1});
    check("raw two", {31'h0, ch_two_raw_output}, {31'h0, w2});
  endtask

  // waits for the overflow interrupt, notes the cycle, then clears it
  task automatic wait_ovf(output int t);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (irq !== 1'b1 && n < 400);
    if (irq !== 1'b1) timed_out();
    t = cyc;
    @(posedge pclk);
    wr(`TC_OFF_STATUS, 32'h1);
  endtask

  initial begin
    modes = '{timer_core_pkg::om_force_low, timer_core_pkg::om_set_on_match,
      timer_core_pkg::om_frozen, timer_core_pkg::om_clr_on_match,
      timer_core_pkg::om_frozen, timer_core_pkg::om_force_high};
    do_reset();
    for (int a = 0; a <= 32; a += 4) begin
      rdc("reset value", 8'(a), 32'h0);
    end
    apb(1'b0, 8'h24, 32'h0);
    check("unmapped data", q, 32'h0);
    check("unmapped error", {31'h0, e}, 32'h1);
    wr(`TC_OFF_COUNT, 32'habcd);
    rdc("count", `TC_OFF_COUNT, 32'habcd);
    wr(`TC_OFF_REPEAT, 32'hffffffff);
    rdc("repeat", `TC_OFF_REPEAT, 32'hff);
    wr(`TC_OFF_REPEAT, 32'h0);
    done("registers");
    c = '0;
    c.ch1_input = 1'b1;
    setc();
    wr(`TC_OFF_COUNT, 32'h42);
    pulse(1'b1, 1'b1);
    rdc("ch1 capture", `TC_OFF_CH1, 32'h42);
    rdc("ch2 no capture", `TC_OFF_CH2, 32'h0);
    c.ch2_input = 1'b1;
    setc();
    wr(`TC_OFF_COUNT, 32'h77);
    pulse(1'b0, 1'b1);
    rdc("ch2 capture", `TC_OFF_CH2, 32'h77);
    rdc("ch1 kept", `TC_OFF_CH1, 32'h42);
    wr(`TC_OFF_COUNT, 32'h55);
    pulse(1'b1, 1'b0);
    rdc("ch1 latest", `TC_OFF_CH1, 32'h55);
    rdc("status", `TC_OFF_STATUS, 32'h6);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(`TC_OFF_MASK, 32'h2);
    @(negedge pclk);
    check("irq on", {31'h0, irq}, 32'h1);
    wr(`TC_OFF_STATUS, 32'h2);
    @(negedge pclk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    done("capture");
    wr(`TC_OFF_STATUS, 32'h7);
    wr(`TC_OFF_MASK, 32'h1);
    wr(`TC_OFF_PERIOD, 32'h9);
    wr(`TC_OFF_DIV, 32'h3);
    wr(`TC_OFF_COUNT, 32'h0);
    c = '0;
    c.run = 1'b1;
    ts = cyc;
    setc();
    wait_ovf(ta);
    check("divider held", 32'(ta - ts < 16), 32'h1);
    wait_ovf(tb);
    wait_ovf(tc);
    check("divided period", 32'(tc - tb), 32'h28);
    wr(`TC_OFF_REPEAT, 32'h2);
    wait_ovf(td);
    wait_ovf(te);
    check("repeat period", 32'(te - td), 32'h78);
    wr(`TC_OFF_PERIOD, 32'h0);
    apb(1'b0, `TC_OFF_COUNT, 32'h0);
    r = q;
    repeat (30) @(posedge pclk);
    rdc("stopped", `TC_OFF_COUNT, r);
    check("no overflow", {31'h0, irq}, 32'h0);
    done("counting");
    do_reset();
    wr(`TC_OFF_PERIOD, 32'h13);
    wr(`TC_OFF_CH1, 32'h5);
    wr(`TC_OFF_CH2, 32'h5);
    c = '0;
    c.run = 1'b1;
    for (int i = 0; i < 6; i++) begin
      c.ch1_mode = modes[i];
      c.ch2_mode = modes[i];
      setc();
      repeat (25) @(negedge pclk);
      raw(want[i], want[i]);
    end
    c.ch1_mode = timer_core_pkg::om_toggle;
    setc();
    repeat (5) @(negedge pclk);
    e0 = edges;
    repeat (100) @(negedge pclk);
    check("toggles", 32'(edges - e0), 32'h5);
    done("modes");
    c = '0;
    c.ch1_mode = timer_core_pkg::om_pwm_a;
    c.ch2_mode = timer_core_pkg::om_pwm_b;
    c.ch1_buf_en = 1'b1;
    setc();
    wr(`TC_OFF_COUNT, 32'h8);
    wr(`TC_OFF_CH1, 32'ha);
    wr(`TC_OFF_CH2, 32'h9);
    repeat (3) @(negedge pclk);
    raw(1'b0, 1'b0);
    wr(`TC_OFF_STATUS, 32'h7);
    wr(`TC_OFF_MASK, 32'h1);
    c.run = 1'b1;
    setc();
    wait_ovf(ta);
    c.run = 1'b0;
    setc();
    wr(`TC_OFF_COUNT, 32'h8);
    repeat (3) @(negedge pclk);
    raw(1'b1, 1'b0);
    c.ch1_mode = timer_core_pkg::om_pwm_b;
    c.ch2_mode = timer_core_pkg::om_pwm_a;
    setc();
    repeat (3) @(negedge pclk);
    raw(1'b0, 1'b1);
    done("buffering");
    results();
  end
endmodule
`default_nettype wire

/* tb/timer_core_pins.sv */
// pin-side model: launches channel input events and counts channel 1 output changes
`timescale 1ns/1ps
`default_nettype none
module timer_core_pins (
  // clock
  input wire logic pclk,
  // requests from the bench
  input wire logic fire_one,
  input wire logic fire_two,
  // pins of the core
  output logic ch_one_input_event,
  output logic ch_two_input_event,
  input wire logic ch_one_raw_output,
  // changes seen on the channel 1 output
  output int edges
);
  logic ev1_q = 1'b0;
  logic ev2_q = 1'b0;
  logic last_q = 1'b0;
  int edges_q = 0;
  // events are one-cycle pulses launched from a clock edge
  always @(posedge pclk) begin
    ev1_q <= fire_one;
    ev2_q <= fire_two;
    last_q <= ch_one_raw_output;
    if (ch_one_raw_output !== last_q) begin
      edges_q <= edges_q + 1;
    end
  end
  assign ch_one_input_event = ev1_q;
  assign ch_two_input_event = ev2_q;
  assign edges = edges_q;
endmodule
`default_nettype wire
